// ---- core/subtract_instruction_unit.sv ----
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module subtract_instruction_unit
	import sub_unit_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// minuend minus subtrahend, flags as the core status expects
	function automatic sub_result_t sub_calc(
		input logic [7:0] minuend,
		input logic [7:0] subtrahend
	);
		sub_result_t r;
		logic no_borrow;
		logic no_nibble_borrow;
		// a compare says the same as the inverted borrow out of a subtractor
		no_borrow = (minuend >= subtrahend); // [RULE_06] [RULE_07]
		no_nibble_borrow = (minuend[3:0] >= subtrahend[3:0]); // [RULE_08]
		r.diff = minuend - subtrahend; // [RULE_07]
		r.flags.carry = no_borrow; // [RULE_06] [RULE_07]
		r.flags.half_carry_flag = no_nibble_borrow; // [RULE_08]
		r.flags.zero = (r.diff == 8'h00); // [RULE_08]
		r.flags.unsupported = 1'b0;
		return r;
	endfunction

	// the five word-aligned register offsets 0x000 to 0x010 only; anything else answers with an error
	function automatic logic addr_known(input logic [ADDR_W-1:0] a);
		logic hit;
		case (a)
			OFS_INSTR: hit = 1'b1;
			OFS_ACC: hit = 1'b1;
			OFS_FLAGS: hit = 1'b1;
			OFS_FILE_ADDR: hit = 1'b1;
			OFS_FILE_DATA: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	logic [7:0] file_mem [FILE_DEPTH];

	logic [7:0] acc_reg;
	logic [7:0] acc_next;
	flags_t flags_reg;
	flags_t flags_next;
	logic [FILE_ADDR_W-1:0] file_addr_reg;
	logic [FILE_ADDR_W-1:0] file_addr_next;

	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;

	logic mem_we;
	logic [FILE_ADDR_W-1:0] mem_waddr;
	logic [7:0] mem_wdata;

	logic complete;
	logic wr_done;
	logic [INSTR_W-1:0] instr;
	logic is_literal;
	logic is_file;
	logic dest_file;
	logic [7:0] lit_operand;
	logic [FILE_ADDR_W-1:0] op_addr;
	logic [7:0] file_operand;
	sub_result_t res;

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

	always_comb begin
		instr = pwdata[INSTR_W-1:0];
		is_literal = (instr[INSTR_W-1:LIT_OP_LSB] == LIT_OPCODE); // [RULE_01]
		is_file = (instr[INSTR_W-1:FILE_OP_LSB] == FILE_OPCODE); // [RULE_03]
		dest_file = instr[DEST_BIT];
		lit_operand = instr[7:0]; // [RULE_01]
		op_addr = instr[FILE_ADDR_W-1:0]; // [RULE_03]
		file_operand = file_mem[op_addr];
		if (is_literal) begin
			res = sub_calc(lit_operand, acc_reg); // [RULE_02]
		end else begin
			res = sub_calc(file_operand, acc_reg); // [RULE_03]
		end
	end

	// pready is registered, so completion uses our own copy of it
	always_comb begin
		complete = psel & penable & pready_reg;
		wr_done = complete & pwrite & addr_known(paddr);
	end

	always_comb begin
		acc_next = acc_reg;
		flags_next = flags_reg;
		file_addr_next = file_addr_reg;
		mem_we = 1'b0;
		mem_waddr = file_addr_reg;
		mem_wdata = pwdata[7:0];

		// writes land only on the edge where the master sees pready
		if (wr_done) begin
			case (paddr)
				OFS_INSTR: begin
					// whole instruction retires on this single edge
					if (is_literal) begin
						acc_next = res.diff; // [RULE_02] [RULE_08]
						flags_next = res.flags;
					end else if (is_file) begin
						flags_next = res.flags;
						if (dest_file) begin
							mem_we = 1'b1; // [RULE_05]
							mem_waddr = op_addr;
							mem_wdata = res.diff;
						end else begin
							acc_next = res.diff; // [RULE_04]
						end
					end else begin
						// other opcodes belong elsewhere in the core; flag and leave state alone
						flags_next.unsupported = 1'b1;
					end
				end
				OFS_ACC: begin
					acc_next = pwdata[7:0];
				end
				OFS_FILE_ADDR: begin
					file_addr_next = pwdata[FILE_ADDR_W-1:0];
				end
				OFS_FILE_DATA: begin
					mem_we = 1'b1;
				end
				OFS_FLAGS: begin
					// status is read-only; the write is dropped with no error
				end
				default: begin
					// unmapped: nothing changes, the error rides on pready
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			acc_reg <= ACC_RESET;
			flags_reg <= FLAGS_RESET;
			file_addr_reg <= FILE_ADDR_RESET;
		end else begin
			acc_reg <= acc_next;
			flags_reg <= flags_next;
			file_addr_reg <= file_addr_next;
		end
	end

	// one wait state keeps every bus output straight from a flop
	always_comb begin
		pready_next = psel & penable & ~pready_reg;
		prdata_next = 32'h0000_0000;
		pslverr_next = 1'b0;
		if (pready_next) begin
			pslverr_next = ~addr_known(paddr);
			if (!pwrite) begin
				case (paddr)
					// write-only: the instruction word reads as zero
					OFS_INSTR: begin
						prdata_next = 32'h0000_0000;
					end
					OFS_ACC: begin
						prdata_next = {24'h00_0000, acc_reg};
					end
					OFS_FLAGS: begin
						prdata_next = {28'h000_0000, flags_reg};
					end
					OFS_FILE_ADDR: begin
						prdata_next = {25'h0, file_addr_reg};
					end
					OFS_FILE_DATA: begin
						prdata_next = {24'h00_0000, file_mem[file_addr_reg]};
					end
					// unmapped words read as zero
					default: begin
						prdata_next = 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// bus answer stays quiet until the first access phase after reset
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			prdata_reg <= BUS_DATA_RESET;
			pready_reg <= BUS_STROBE_RESET;
			pslverr_reg <= BUS_STROBE_RESET;
		end else begin
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// data memory is not cleared by reset, like the core's general registers
	always_ff @(posedge ref_clk) begin
		if (mem_we) begin
			file_mem[mem_waddr] <= mem_wdata;
		end
	end

endmodule
`default_nettype wire

// ---- core/sub_unit_pkg.sv ----
// Summary of operation
// RULE_01: literal subtract decoded when word bits 13..9 are 11110; low byte is literal.
// RULE_02: literal subtract computes literal minus accumulator, result into accumulator.
// RULE_03: file subtract decoded from 000010, destination bit, 7-bit register address.
// RULE_04: destination clear: difference goes to accumulator, file register untouched.
// RULE_05: destination set: difference goes to file register, accumulator untouched.
// RULE_06: carry set when minuend is greater than or equal to subtrahend.
// RULE_07: carry cleared on borrow; wrapped 8-bit difference is stored.
// RULE_08: zero on zero result, half carry on no nibble borrow, one cycle.
package sub_unit_pkg;
	localparam int ADDR_W = 12;
	localparam int INSTR_W = 14;
	localparam int FILE_ADDR_W = 7;
	localparam int FILE_DEPTH = 128;

	localparam logic [ADDR_W-1:0] OFS_INSTR = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_ACC = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_FLAGS = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_FILE_ADDR = 12'h00C;
	localparam logic [ADDR_W-1:0] OFS_FILE_DATA = 12'h010;

	localparam logic [4:0] LIT_OPCODE = 5'h1E;
	localparam logic [5:0] FILE_OPCODE = 6'h02;
	localparam int LIT_OP_LSB = 9;
	localparam int FILE_OP_LSB = 8;
	localparam int DEST_BIT = 7;

	localparam int FLAG_CARRY_BIT = 0;
	localparam int FLAG_HALF_BIT = 1;
	localparam int FLAG_ZERO_BIT = 2;
	localparam int FLAG_UNSUP_BIT = 3;

	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [FILE_ADDR_W-1:0] FILE_ADDR_RESET = 7'h00;
	localparam logic [31:0] BUS_DATA_RESET = 32'h0000_0000;
	localparam logic BUS_STROBE_RESET = 1'b0;

	typedef struct packed {
		logic unsupported;
		logic zero;
		logic half_carry_flag;
		logic carry;
	} flags_t;

	localparam flags_t FLAGS_RESET = 4'h0;

	typedef struct packed {
		logic [7:0] diff;
		flags_t flags;
	} sub_result_t;
endpackage

// ---- tb/sub_unit_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module sub_unit_properties
	import sub_unit_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	a_ready_wait: assert property ($rose(penable) && psel |=> pready) else $error("late");
	a_ready_pulse: assert property (pready |=> !pready) else $error("held");
	a_ready_access: assert property (pready |-> psel && penable) else $error("stray");
	a_setup_quiet: assert property (psel && !penable |=> !pready) else $error("early");
	a_err_ready: assert property (pslverr |-> pready) else $error("err");
	a_data_idle: assert property (!pready |-> prdata == 32'h0) else $error("data");
	a_unmapped_err: assert property (pready && paddr > OFS_FILE_DATA |-> pslverr) else $error("map");
	a_flags_width: assert property (pready && !pwrite && paddr == OFS_FLAGS |-> prdata[31:4] == 28'h0) else $error("wide");
endmodule
bind subtract_instruction_unit sub_unit_properties u_props(.ref_clk, .reset, .psel, .penable, .pwrite, .pready, .pslverr, .paddr, .prdata);
`default_nettype wire

// ---- tb/apb_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module apb_host
	import sub_unit_pkg::*;
(
	input wire logic ref_clk,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [ADDR_W-1:0] paddr,
	output logic [31:0] pwdata
);
	initial {psel, penable, pwrite, paddr, pwdata} = '0;
	// one idle cycle between transfers keeps each request edge unique
	task automatic xfer(
		input logic w,
		input logic [ADDR_W-1:0] a,
		input logic [31:0] d,
		output logic [31:0] q,
		output logic e,
		output bit to
	);
		int n;
		n = 0;
		@(posedge ref_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
		@(posedge ref_clk);
		penable <= 1'h1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'h1 && n < 16);
		q = prdata;
		e = pslverr;
		to = pready !== 1'h1;
		{psel, penable} <= 2'h0;
	endtask
endmodule
`default_nettype wire

// ---- tb/subtract_instruction_unit_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module subtract_instruction_unit_tb_top;
	import sub_unit_pkg::*;
	logic ref_clk = 1'h0;
	logic reset = 1'h1;
	logic psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic slv_err;
	int err_total = 0;
	int n_compared = 0;
	always #2 ref_clk = ~ref_clk;
	subtract_instruction_unit u_dut(.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
	apb_host u_host(.ref_clk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
	task automatic give_verdict();
		$display("compared %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		bit to;
		u_host.xfer(w, a, d, q, slv_err, to);
		if (to) begin
			err_total++;
			give_verdict();
		end
	endtask
	// pointer taken from the low word bits so both forms share one flow
	task automatic run(input logic [13:0] i, input logic [7:0] m, a, ea, em, input logic [3:0] ef);
		bus(1'h1, OFS_FILE_ADDR, 32'(i[6:0]));
		bus(1'h1, OFS_FILE_DATA, 32'(m));
		bus(1'h1, OFS_ACC, 32'(a));
		bus(1'h1, OFS_INSTR, 32'(i));
		bus(1'h0, OFS_ACC, 32'h0);
		chk(q, 32'(ea));
		bus(1'h0, OFS_FILE_DATA, 32'h0);
		chk(q, 32'(em));
		bus(1'h0, OFS_FLAGS, 32'h0);
		chk(q, 32'(ef));
		chk(32'(slv_err), 32'h0);
	endtask
	task automatic t_reset();
		bus(1'h0, OFS_ACC, 32'h0);
		chk(q, 32'(ACC_RESET));
		bus(1'h0, OFS_FLAGS, 32'h0);
		chk(q, 32'(FLAGS_RESET));
		$display("reset done");
	endtask
	task automatic t_literal();
		run(14'h3D02, 8'h55, 8'h01, 8'h01, 8'h55, 4'h3);
		run(14'h3C02, 8'h55, 8'h03, 8'hFF, 8'h55, 4'h0);
		$display("literal done");
	endtask
	task automatic t_file();
		run(14'h0203, 8'h05, 8'h02, 8'h03, 8'h05, 4'h3);
		run(14'h027F, 8'h02, 8'h02, 8'h00, 8'h02, 4'h7);
		run(14'h0285, 8'h01, 8'h02, 8'h02, 8'hFF, 4'h0);
		run(14'h02FF, 8'h10, 8'h01, 8'h01, 8'h0F, 4'h1);
		$display("file done");
	endtask
	task automatic t_other();
		run(14'h3A00, 8'h0F, 8'h01, 8'h01, 8'h0F, 4'h9);
		bus(1'h0, 12'h100, 32'h0);
		chk(q, 32'h0);
		chk(32'(slv_err), 32'h1);
		$display("other done");
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		reset <= 1'h0;
		t_reset();
		t_literal();
		t_file();
		t_other();
		give_verdict();
	end
endmodule
`default_nettype wire
